// *** shared/io_decode_pkg.sv ***
// Shared constants and the fixed-range lookup for the legacy I/O address decoder
package io_decode_pkg;

  typedef enum logic [4:0] {
    T_NONE  = 5'h00, T_PCI   = 5'h01, T_DMA   = 5'h02, T_INTC = 5'h03,
    T_TIMER = 5'h04, T_RTC   = 5'h05, T_RESET = 5'h06, T_NMI  = 5'h07,
    T_FPU   = 5'h08, T_PM    = 5'h09, T_LPC   = 5'h0a, T_SATA = 5'h0b,
    T_IDE   = 5'h0c, T_USB   = 5'h0d, T_SMBUS = 5'h0e, T_WDOG = 5'h0f,
    T_GPIO  = 5'h10, T_LAN   = 5'h11, T_TRAP  = 5'h12, T_RSVD = 5'h13
  } tgt_e;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned N_VAR  = 13;
  // Variable window index: 0 PM, 1 IDE bus master, 2 IDE command, 3 IDE control,
  // 4..9 USB units, 10 SMBus, 11 GPIO, 12 LAN. Entry holds log2 of window size.
  localparam int unsigned VAR_LOG2 [N_VAR] = '{6, 4, 3, 2, 5, 5, 5, 5, 5, 5, 5, 6, 5};
  localparam int unsigned V_PM = 0;
  localparam int unsigned V_USB0 = 4;
  localparam int unsigned V_SMB = 10;
  localparam int unsigned V_GPIO = 11;
  localparam int unsigned V_LAN = 12;
  localparam logic [15:0] WDOG_OFFSET = 16'h0060;
  localparam int unsigned WDOG_LOG2 = 5;
  localparam int unsigned LEG_LOG2 = 3;
  localparam int unsigned N_GEN = 4;
  localparam int unsigned N_TRAP = 4;
  localparam logic [15:0] POST_ADDR = 16'h0080;
  localparam logic [15:0] F0_ADDR   = 16'h00f0;
  localparam logic [15:0] SATA_SEC_CMD = 16'h0170;
  localparam logic [15:0] SATA_PRI_CMD = 16'h01f0;
  localparam logic [15:0] SATA_SEC_CTL = 16'h0376;
  localparam logic [15:0] SATA_PRI_CTL = 16'h03f6;

  function automatic logic in_rng(input logic [7:0] b, input logic [7:0] lo, input logic [7:0] hi);
    in_rng = (b >= lo) && (b <= hi);
  endfunction : in_rng

  // Fixed legacy map; T_RSVD marks a direction that is not decoded there
  function automatic tgt_e fixed_target(input logic [15:0] a, input logic wr);
    tgt_e       t;
    logic [7:0] b;
    t = T_NONE;
    b = a[7:0];
    if (a[15:8] == 8'h00) begin
      if (in_rng(b, 8'h00, 8'h08) || b == 8'h0f || in_rng(b, 8'h10, 8'h18) || b == 8'h1f ||
          (in_rng(b, 8'h81, 8'h9f) && b != 8'h92) || in_rng(b, 8'h80, 8'h80) ||
          in_rng(b, 8'hc0, 8'hd1) || in_rng(b, 8'hde, 8'hdf))
        t = T_DMA;
      else if (in_rng(b, 8'h09, 8'h0e) || in_rng(b, 8'h19, 8'h1e) || in_rng(b, 8'hd2, 8'hdd))
        t = wr ? T_DMA : T_RSVD;
      else if ((in_rng(b, 8'h20, 8'h3d) || (in_rng(b, 8'ha0, 8'hbd) && b[7:1] != 7'h59)) && !b[1])
        t = T_INTC;
      else if (b == 8'h2e || b == 8'h2f || b == 8'h4e || b == 8'h4f ||
               b == 8'h60 || b == 8'h62 || b == 8'h64 || b == 8'h66)
        t = T_LPC;
      else if (in_rng(b, 8'h40, 8'h42) || in_rng(b, 8'h50, 8'h52))
        t = T_TIMER;
      else if (b == 8'h43 || b == 8'h53)
        t = wr ? T_TIMER : T_RSVD;
      else if (b == 8'h61)
        t = T_NMI;
      else if (b == 8'h70)
        t = wr ? T_RTC : T_RSVD;
      else if (in_rng(b, 8'h71, 8'h77))
        t = T_RTC;
      else if (b == 8'h92)
        t = T_RESET;
      else if (b == 8'hb2 || b == 8'hb3)
        t = T_PM;
      else if (b == F0_ADDR[7:0])
        t = wr ? T_FPU : T_RSVD;
    end else if (a[15:1] == 15'h0268) begin
      t = T_INTC;
    end else if (a == 16'h0cf9) begin
      t = T_RESET;
    end
    fixed_target = t;
  endfunction : fixed_target

endpackage : io_decode_pkg

// *** design/legacy_io_address_decoder.sv ***
// Legacy I/O-space cycle classifier and router with one registered result stage
`timescale 1ns/1ps

module legacy_io_address_decoder
  import io_decode_pkg::*;
#(
  parameter logic [15:0] PAR_BASES [3] = '{16'h0100, 16'h0108, 16'h0110},
  parameter logic [15:0] SER_BASES [8] = '{16'h0200, 16'h0208, 16'h0210, 16'h0218,
                                          16'h0220, 16'h0228, 16'h0230, 16'h0238},
  parameter logic [15:0] FDC_BASES [2] = '{16'h0300, 16'h0308}
) (
  input  wire logic                    CLK,
  input  wire logic                    RST,
  input  wire logic                    REQ_VALID,
  input  wire logic                    REQ_WRITE,
  input  wire logic                    REQ_FROM_PCI,
  input  wire logic [ADDR_W-1:0]       REQ_ADDR,
  input  wire logic                    SUBTRACTIVE_POLICY,
  input  wire logic                    SATA_PRI_CLAIM,
  input  wire logic                    SATA_SEC_CLAIM,
  input  wire logic                    POST_TO_LPC,
  input  wire logic                    POST_READ_DMA,
  input  wire logic [N_VAR*16-1:0]     VAR_BASE,
  input  wire logic [N_VAR-1:0]        VAR_EN,
  input  wire logic                    WDOG_EN,
  input  wire logic [3:0]              LEG_EN,
  input  wire logic [1:0]              PAR_SEL,
  input  wire logic [2:0]              SER1_SEL,
  input  wire logic [2:0]              SER2_SEL,
  input  wire logic                    FDC_SEL,
  input  wire logic [N_GEN*16-1:0]     GEN_BASE,
  input  wire logic [N_GEN*6-1:0]      GEN_MASK,
  input  wire logic [N_GEN-1:0]        GEN_EN,
  input  wire logic [N_TRAP*16-1:0]    TRAP_BASE,
  input  wire logic [N_TRAP*8-1:0]     TRAP_MASK,
  input  wire logic [N_TRAP-1:0]       TRAP_EN,
  output logic                         DEC_VALID,
  output tgt_e                         DEC_TARGET,
  output logic [2:0]                   DEC_INDEX,
  output logic                         DEC_POSITIVE,
  output logic                         DEC_MEDIUM,
  output logic                         DEC_ALSO_NMI,
  output logic                         DEC_ALSO_INTC,
  output logic                         DEC_ALSO_LPC,
  output logic                         DEC_ALSO_PCI,
  output logic                         DEC_WRITE,
  output logic [ADDR_W-1:0]            DEC_ADDR
);

  // Aligned window match: low bits under the mask are don't-care
  function automatic logic win_hit(input logic [15:0] a, input logic [15:0] base, input logic [15:0] mask);
    win_hit = ((a ^ base) & ~mask) == 16'h0000;
  endfunction : win_hit

  tgt_e             fixed_t;
  logic [N_VAR-1:0] var_hit;
  logic [3:0]       leg_hit;
  logic [N_GEN-1:0] gen_hit;
  logic [N_TRAP-1:0] trap_hit;
  logic             wdog_hit;
  logic             var_any;
  logic [15:0]      wdog_base;
  logic [15:0]      leg_base [4];

  assign fixed_t   = fixed_target(REQ_ADDR, REQ_WRITE);
  assign wdog_base = VAR_BASE[V_PM*16 +: 16] + WDOG_OFFSET;
  assign leg_base[0] = (PAR_SEL == 2'd3) ? PAR_BASES[0] : PAR_BASES[PAR_SEL];
  assign leg_base[1] = SER_BASES[SER1_SEL];
  assign leg_base[2] = SER_BASES[SER2_SEL];
  assign leg_base[3] = FDC_BASES[FDC_SEL];

  // Disabled window or function matches nothing and falls through
  genvar gi;
  generate
    for (gi = 0; gi < N_VAR; gi++) begin : g_var
      localparam logic [15:0] MASK = 16'((32'd1 << VAR_LOG2[gi]) - 32'd1);
      assign var_hit[gi] = VAR_EN[gi] && win_hit(REQ_ADDR, VAR_BASE[gi*16 +: 16], MASK);
    end
    for (gi = 0; gi < 4; gi++) begin : g_leg
      assign leg_hit[gi] = LEG_EN[gi] && win_hit(REQ_ADDR, leg_base[gi], 16'h0007);
    end
    for (gi = 0; gi < N_GEN; gi++) begin : g_gen
      assign gen_hit[gi] = GEN_EN[gi] &&
                           win_hit(REQ_ADDR, GEN_BASE[gi*16 +: 16], {8'h00, GEN_MASK[gi*6 +: 6], 2'b11});
    end
    for (gi = 0; gi < N_TRAP; gi++) begin : g_trap
      assign trap_hit[gi] = TRAP_EN[gi] &&
                            win_hit(REQ_ADDR, TRAP_BASE[gi*16 +: 16], {8'h00, TRAP_MASK[gi*8 +: 8]});
    end
  endgenerate

  // Watchdog has no base of its own and dies with the PM window
  assign wdog_hit = VAR_EN[V_PM] && WDOG_EN && win_hit(REQ_ADDR, wdog_base, 16'h001f);
  assign var_any  = (|var_hit) || wdog_hit || (|leg_hit) || (|gen_hit) || (|trap_hit);

  function automatic logic [2:0] first_idx(input logic [5:0] v);
    first_idx = 3'd0;
    for (int i = 5; i >= 0; i--) begin
      if (v[i])
        first_idx = 3'(i);
    end
  endfunction : first_idx

  tgt_e       tgt_d;
  logic [2:0] idx_d;
  logic       nmi_d;
  logic       intc_d;
  logic       lpc_d;
  logic       pci_d;
  logic       fixed_pos;
  logic       sata_port;
  logic       sata_claim;

  always_comb begin
    tgt_d      = T_NONE;
    idx_d      = 3'd0;
    nmi_d      = 1'b0;
    intc_d     = 1'b0;
    lpc_d      = 1'b0;
    pci_d      = 1'b0;
    fixed_pos  = 1'b0;
    sata_port  = REQ_ADDR[15:3] == SATA_SEC_CMD[15:3] || REQ_ADDR[15:3] == SATA_PRI_CMD[15:3] ||
                 REQ_ADDR == SATA_SEC_CTL || REQ_ADDR == SATA_PRI_CTL;
    sata_claim = (REQ_ADDR[15:3] == SATA_SEC_CMD[15:3] || REQ_ADDR == SATA_SEC_CTL) ? SATA_SEC_CLAIM
                                                                                     : SATA_PRI_CLAIM;
    if (fixed_t != T_NONE && fixed_t != T_RSVD) begin
      tgt_d     = fixed_t;
      fixed_pos = 1'b1;
      if (fixed_t == T_RTC && REQ_WRITE && REQ_ADDR[0] == 1'b0)
        nmi_d = 1'b1;
      if (fixed_t == T_FPU)
        intc_d = 1'b1;
      // PCI masters keep 80h reads on DMA so their fixed hit stays positive
      if (REQ_ADDR == POST_ADDR && !REQ_WRITE && !POST_READ_DMA && !REQ_FROM_PCI) begin
        tgt_d     = POST_TO_LPC ? T_LPC : T_PCI;
        fixed_pos = POST_TO_LPC;
      end
      if (REQ_WRITE && REQ_ADDR[15:4] == POST_ADDR[15:4] &&
          (REQ_ADDR[3:0] == 4'h0 || REQ_ADDR[3:0] == 4'h8 || REQ_ADDR[1:0] != 2'b11) &&
          REQ_ADDR[3:0] != 4'h1 && REQ_ADDR[3:0] != 4'h2 && REQ_ADDR[3:0] != 4'h9 && REQ_ADDR[3:0] != 4'ha) begin
        lpc_d = POST_TO_LPC;
        pci_d = !POST_TO_LPC;
      end
    end else if (sata_port && fixed_t == T_NONE && sata_claim) begin
      tgt_d     = T_SATA;
      fixed_pos = 1'b1;
    end else if (|trap_hit) begin
      tgt_d = T_TRAP;
      idx_d = first_idx({2'b00, trap_hit});
    end else if (var_hit[V_PM]) begin
      tgt_d = T_PM;
    end else if (wdog_hit) begin
      tgt_d = T_WDOG;
    end else if (|var_hit[3:1]) begin
      tgt_d = T_IDE;
      idx_d = first_idx({3'b000, var_hit[3:1]});
    end else if (|var_hit[9:4]) begin
      tgt_d = T_USB;
      idx_d = first_idx(var_hit[9:4]);
    end else if (var_hit[V_SMB]) begin
      tgt_d = T_SMBUS;
    end else if (var_hit[V_GPIO]) begin
      tgt_d = T_GPIO;
    end else if (var_hit[V_LAN]) begin
      tgt_d = T_LAN;
    end else if ((|leg_hit) || (|gen_hit)) begin
      tgt_d = T_LPC;
      idx_d = (|leg_hit) ? first_idx({2'b00, leg_hit}) : 3'(4 + first_idx({2'b00, gen_hit}));
    end else if (!REQ_FROM_PCI && !SUBTRACTIVE_POLICY) begin
      tgt_d = T_PCI;
    end
  end

  // One registered stage: result appears on the edge after the request
  always_ff @(posedge CLK) begin
    if (RST) begin
      DEC_VALID <= 1'b0;
    end else begin
      DEC_VALID <= REQ_VALID;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      DEC_TARGET    <= T_NONE;
      DEC_INDEX     <= 3'd0;
      DEC_POSITIVE  <= 1'b0;
      DEC_MEDIUM    <= 1'b0;
      DEC_ALSO_NMI  <= 1'b0;
      DEC_ALSO_INTC <= 1'b0;
      DEC_ALSO_LPC  <= 1'b0;
      DEC_ALSO_PCI  <= 1'b0;
      DEC_WRITE     <= 1'b0;
      DEC_ADDR      <= 16'h0000;
    end else if (REQ_VALID) begin
      DEC_TARGET    <= tgt_d;
      DEC_INDEX     <= idx_d;
      DEC_POSITIVE  <= tgt_d != T_PCI && tgt_d != T_NONE;
      DEC_MEDIUM    <= REQ_FROM_PCI && fixed_pos;
      DEC_ALSO_NMI  <= nmi_d;
      DEC_ALSO_INTC <= intc_d;
      DEC_ALSO_LPC  <= lpc_d;
      DEC_ALSO_PCI  <= pci_d;
      DEC_WRITE     <= REQ_WRITE;
      DEC_ADDR      <= REQ_ADDR;
    end
  end

  property p_rsvd_to_pci;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && !REQ_FROM_PCI && !SUBTRACTIVE_POLICY && fixed_t == T_RSVD && !var_any
      |=> DEC_VALID && DEC_TARGET == T_PCI && !DEC_POSITIVE;
  endproperty
  a_rsvd_to_pci: assert property (p_rsvd_to_pci) else $error("reserved link cycle not sent to PCI");

  property p_pci_medium;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && REQ_FROM_PCI && fixed_t inside {T_DMA, T_INTC, T_TIMER, T_RTC, T_RESET, T_NMI}
      |=> DEC_MEDIUM && DEC_POSITIVE;
  endproperty
  a_pci_medium: assert property (p_pci_medium) else $error("PCI master fixed hit not claimed medium");

  property p_dma_wo_read;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && !REQ_WRITE && !var_any &&
      REQ_ADDR inside {[16'h0009:16'h000e], [16'h0019:16'h001e], [16'h00d2:16'h00dd]}
      |=> DEC_TARGET != T_DMA && !DEC_POSITIVE;
  endproperty
  a_dma_wo_read: assert property (p_dma_wo_read) else $error("read of write-only DMA port claimed");

  property p_rtc_nmi;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && REQ_WRITE && REQ_ADDR[15:3] == 13'h000e && !REQ_ADDR[0]
      |=> DEC_TARGET == T_RTC && DEC_ALSO_NMI && $past(REQ_ADDR) == DEC_ADDR;
  endproperty
  a_rtc_nmi: assert property (p_rtc_nmi) else $error("RTC even write missed NMI copy");

  property p_post_write;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && REQ_WRITE && REQ_ADDR == POST_ADDR
      |=> DEC_TARGET == T_DMA && (DEC_ALSO_LPC != DEC_ALSO_PCI) && DEC_ALSO_LPC == $past(POST_TO_LPC);
  endproperty
  a_post_write: assert property (p_post_write) else $error("POST write not copied out");

  property p_f0_write;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && REQ_WRITE && REQ_ADDR == F0_ADDR |=> DEC_TARGET == T_FPU && DEC_ALSO_INTC;
  endproperty
  a_f0_write: assert property (p_f0_write) else $error("F0 write misrouted");

  property p_sata_unclaimed;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && !REQ_FROM_PCI && !SUBTRACTIVE_POLICY && REQ_ADDR[15:3] == SATA_PRI_CMD[15:3] &&
      !SATA_PRI_CLAIM && !var_any
      |=> DEC_TARGET == T_PCI;
  endproperty
  a_sata_unclaimed: assert property (p_sata_unclaimed) else $error("unclaimed disk port not sent to PCI");

  property p_wdog_off;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && !VAR_EN[V_PM] && fixed_t == T_NONE |=> DEC_TARGET != T_WDOG && DEC_TARGET != T_PM;
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("disabled PM window still decoded");

  property p_sata_claimed;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && (REQ_ADDR == SATA_PRI_CTL || REQ_ADDR[15:3] == SATA_PRI_CMD[15:3]) && SATA_PRI_CLAIM
      |=> DEC_TARGET == T_SATA && DEC_POSITIVE && DEC_MEDIUM == $past(REQ_FROM_PCI);
  endproperty
  a_sata_claimed: assert property (p_sata_claimed) else $error("claimed disk port not sent to SATA");

  property p_pm_window;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && VAR_EN[V_PM] && fixed_t == T_NONE && !sata_port && trap_hit == '0 &&
      REQ_ADDR[15:6] == VAR_BASE[V_PM*16+6 +: 10]
      |=> DEC_TARGET == T_PM && DEC_POSITIVE && DEC_INDEX == 3'd0;
  endproperty
  a_pm_window: assert property (p_pm_window) else $error("enabled PM window not decoded");

  property p_pci_unclaimed;
    @(posedge CLK) disable iff (RST)
      REQ_VALID && REQ_FROM_PCI && fixed_t == T_NONE && !sata_port && !var_any
      |=> DEC_VALID && DEC_TARGET == T_NONE && !DEC_POSITIVE && !DEC_MEDIUM;
  endproperty
  a_pci_unclaimed: assert property (p_pci_unclaimed) else $error("unlisted PCI master cycle claimed");

endmodule : legacy_io_address_decoder

// *** dv/io_requester.sv ***
// Upstream link and PCI master model issuing one I/O cycle per clock
`timescale 1ns/1ps
module io_requester (
  input  wire logic        CLK,
  output logic             REQ_VALID,
  output logic             REQ_WRITE,
  output logic             REQ_FROM_PCI,
  output logic [15:0]      REQ_ADDR
);
  initial begin
    REQ_VALID    = 1'b0;
    REQ_WRITE    = 1'b0;
    REQ_FROM_PCI = 1'b0;
    REQ_ADDR     = 16'h0000;
  end

  // Consecutive calls give back-to-back cycles with no idle gap
  task automatic issue(input logic [15:0] a, input logic w, input logic p);
    @(negedge CLK);
    REQ_VALID    = 1'b1;
    REQ_WRITE    = w;
    REQ_FROM_PCI = p;
    REQ_ADDR     = a;
  endtask : issue

  // Address and direction flip when idle so a stale cycle cannot look valid
  task automatic idle();
    @(negedge CLK);
    REQ_VALID = 1'b0;
    REQ_ADDR  = ~REQ_ADDR;
    REQ_WRITE = ~REQ_WRITE;
  endtask : idle
endmodule : io_requester

// *** dv/test_legacy_io_address_decoder.sv ***
// Self-checking bench for the legacy I/O address decoder
`timescale 1ns/1ps
module test_legacy_io_address_decoder
  import io_decode_pkg::*;
;
  typedef struct packed {logic ph; logic [15:0] a; logic w; logic p; tgt_e t;} row_s;
  typedef struct packed {tgt_e t; logic [5:0] f; logic [15:0] a; logic w; logic [2:0] x;} exp_s;
  localparam int NR = 33;
  localparam row_s ROWS [NR] = '{
    '{1'b0, 16'h0009, 1'b0, 1'b0, T_PCI}, '{1'b0, 16'h0009, 1'b1, 1'b0, T_DMA},
    '{1'b0, 16'h00dd, 1'b0, 1'b0, T_PCI}, '{1'b0, 16'h00dd, 1'b1, 1'b0, T_DMA},
    '{1'b0, 16'h00c0, 1'b0, 1'b0, T_DMA}, '{1'b0, 16'h0092, 1'b0, 1'b0, T_RESET},
    '{1'b0, 16'h0cf9, 1'b1, 1'b0, T_RESET}, '{1'b0, 16'h04d1, 1'b0, 1'b0, T_INTC},
    '{1'b0, 16'h00bd, 1'b1, 1'b0, T_INTC}, '{1'b0, 16'h0022, 1'b0, 1'b0, T_PCI},
    '{1'b0, 16'h00b3, 1'b1, 1'b0, T_PM}, '{1'b0, 16'h002f, 1'b0, 1'b0, T_LPC},
    '{1'b0, 16'h0066, 1'b1, 1'b0, T_LPC}, '{1'b0, 16'h0043, 1'b0, 1'b0, T_PCI},
    '{1'b0, 16'h0053, 1'b1, 1'b0, T_TIMER}, '{1'b0, 16'h0061, 1'b1, 1'b0, T_NMI},
    '{1'b0, 16'h0070, 1'b1, 1'b0, T_RTC}, '{1'b0, 16'h0070, 1'b0, 1'b0, T_PCI},
    '{1'b0, 16'h0076, 1'b1, 1'b0, T_RTC}, '{1'b0, 16'h0077, 1'b1, 1'b0, T_RTC},
    '{1'b0, 16'h0080, 1'b1, 1'b0, T_DMA}, '{1'b0, 16'h0080, 1'b0, 1'b0, T_DMA},
    '{1'b0, 16'h00f0, 1'b1, 1'b0, T_FPU}, '{1'b0, 16'h00f0, 1'b0, 1'b0, T_PCI},
    '{1'b0, 16'h01f0, 1'b0, 1'b0, T_PCI}, '{1'b0, 16'h0041, 1'b0, 1'b1, T_TIMER},
    '{1'b0, 16'h0177, 1'b0, 1'b0, T_PCI}, '{1'b0, 16'h00e0, 1'b0, 1'b1, T_NONE},
    '{1'b1, 16'h0009, 1'b0, 1'b0, T_NONE}, '{1'b1, 16'h0376, 1'b1, 1'b0, T_SATA},
    '{1'b1, 16'h03f6, 1'b1, 1'b1, T_SATA}, '{1'b1, 16'h008d, 1'b1, 1'b0, T_DMA},
    '{1'b1, 16'h0080, 1'b0, 1'b0, T_PCI}};
  logic clk, rst, policy, pri, sec, post_lpc, post_dma, wdog_en, fdc_sel;
  logic req_valid, req_write, req_pci, dec_valid, dec_pos, dec_med, dec_nmi, dec_intc, dec_lpc, dec_pci, dec_write;
  logic [15:0] req_addr, dec_addr, usb;
  logic [N_VAR*16-1:0] var_base;
  logic [N_VAR-1:0] var_en;
  logic [3:0] leg_en;
  logic [1:0] par_sel;
  logic [2:0] ser1_sel, ser2_sel, dec_index;
  logic [N_GEN*16-1:0] gen_base;
  logic [N_GEN*6-1:0] gen_mask;
  logic [N_GEN-1:0] gen_en;
  logic [N_TRAP*16-1:0] trap_base;
  logic [N_TRAP*8-1:0] trap_mask;
  logic [N_TRAP-1:0] trap_en;
  tgt_e dec_target;
  exp_s exp_q[$];
  exp_s cur;
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'he6029f98;

  io_requester src_i (.CLK(clk), .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_FROM_PCI(req_pci),
    .REQ_ADDR(req_addr));
  legacy_io_address_decoder #(.FDC_BASES('{16'h0a00, 16'h0a08})) legacy_io_address_decoder_i (
    .CLK(clk), .RST(rst), .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_FROM_PCI(req_pci),
    .REQ_ADDR(req_addr), .SUBTRACTIVE_POLICY(policy), .SATA_PRI_CLAIM(pri), .SATA_SEC_CLAIM(sec),
    .POST_TO_LPC(post_lpc), .POST_READ_DMA(post_dma), .VAR_BASE(var_base), .VAR_EN(var_en),
    .WDOG_EN(wdog_en), .LEG_EN(leg_en), .PAR_SEL(par_sel), .SER1_SEL(ser1_sel), .SER2_SEL(ser2_sel),
    .FDC_SEL(fdc_sel), .GEN_BASE(gen_base), .GEN_MASK(gen_mask), .GEN_EN(gen_en), .TRAP_BASE(trap_base),
    .TRAP_MASK(trap_mask), .TRAP_EN(trap_en), .DEC_VALID(dec_valid), .DEC_TARGET(dec_target),
    .DEC_INDEX(dec_index), .DEC_POSITIVE(dec_pos), .DEC_MEDIUM(dec_med), .DEC_ALSO_NMI(dec_nmi),
    .DEC_ALSO_INTC(dec_intc), .DEC_ALSO_LPC(dec_lpc), .DEC_ALSO_PCI(dec_pci), .DEC_WRITE(dec_write),
    .DEC_ADDR(dec_addr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic results();
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk_tgt(input tgt_e got, input tgt_e exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_tgt

  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec

  // Flags follow from the target: positive unless PCI or nobody, medium only for PCI masters
  task automatic send(input logic [15:0] a, input logic w, input logic p, input tgt_e t, input logic [2:0] x = 3'd0);
    logic pst;
    logic pos;
    pst = a == POST_ADDR || (a >= 16'h0084 && a <= 16'h0086) || a == 16'h0088 || (a >= 16'h008c && a <= 16'h008e);
    pos = t != T_PCI && t != T_NONE;
    exp_q.push_back('{t, {pos, p && pos, w && t == T_RTC && !a[0], w && a == F0_ADDR,
                          w && pst && post_lpc, w && pst && !post_lpc}, a, w, x});
    src_i.issue(a, w, p);
  endtask : send

  task automatic drain();
    src_i.idle();
    repeat (3) @(negedge clk);
  endtask : drain

  always @(negedge clk) begin
    if (dec_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, dec_valid, 1'b0);
      end else begin
        cur = exp_q.pop_front();
        chk_tgt(dec_target, cur.t);
        chk_vec({10'h000, dec_pos, dec_med, dec_nmi, dec_intc, dec_lpc, dec_pci}, {10'h000, cur.f});
        chk_vec(dec_addr, cur.a);
        chk_vec({13'h0000, dec_index}, {13'h0000, cur.x});
        chk_vec({15'h0000, dec_write}, {15'h0000, cur.w});
      end
    end
  end

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    {rst, policy, pri, sec, post_lpc, post_dma} = 6'b100011;
    {wdog_en, fdc_sel, var_base, var_en, leg_en, gen_base, gen_mask, gen_en} = '0;
    {trap_base, trap_mask, trap_en, ser1_sel} = '0;
    seed = lfsr(seed);
    par_sel = {1'b0, seed[0]};
    ser2_sel = seed[3:1];
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk_tgt(dec_target, T_NONE);
    for (int i = 0; i < NR; i++) begin
      if (ROWS[i].ph && !policy) begin
        drain();
        {policy, pri, sec, post_lpc, post_dma} = 5'b11100;
      end
      send(ROWS[i].a, ROWS[i].w, ROWS[i].p, ROWS[i].t);
    end
    drain();
    // Variable windows kept clear of the fixed map and of each other
    seed = lfsr(seed);
    usb = {2'b10, seed[13:5], 5'h00};
    {policy, var_en, wdog_en, leg_en, fdc_sel, gen_en, trap_en} = {1'b0, 13'h0011, 1'b1, 4'h8, 1'b1, 4'h1, 4'h1};
    var_base[V_PM*16+:16] = 16'h1000;
    var_base[V_USB0*16+:16] = usb;
    gen_base[15:0] = 16'h0800;
    gen_mask[5:0] = 6'h03;
    trap_base[15:0] = 16'h0900;
    send(16'h103f, 1'b0, 1'b0, T_PM);
    send(16'h1040, 1'b0, 1'b0, T_PCI);
    send(16'h1060 + {11'h000, seed[4:0]}, 1'b1, 1'b0, T_WDOG);
    send(16'h1080, 1'b0, 1'b0, T_PCI);
    send(usb + 16'h001f, 1'b0, 1'b0, T_USB);
    send(usb + 16'h0020, 1'b0, 1'b0, T_PCI);
    send(16'h0a0f, 1'b1, 1'b0, T_LPC, 3'd3);
    send(16'h0a10, 1'b1, 1'b0, T_PCI);
    send(16'h080f, 1'b0, 1'b0, T_LPC, 3'd4);
    send(16'h0810, 1'b0, 1'b0, T_PCI);
    send(16'h0900, 1'b1, 1'b0, T_TRAP);
    send(16'h0901, 1'b1, 1'b0, T_PCI);
    drain();
    var_en = 13'h0010;
    wdog_en = 1'b0;
    var_base[V_USB0*16+:16] = {2'b11, seed[13:5], 5'h00};
    send(16'h1000, 1'b0, 1'b0, T_PCI);
    send(16'h1060, 1'b0, 1'b0, T_PCI);
    send(usb, 1'b0, 1'b0, T_PCI);
    send({2'b11, seed[13:5], 5'h00}, 1'b1, 1'b0, T_USB);
    drain();
    if (exp_q.size() != 0) error_cnt++;
    results();
  end
endmodule : test_legacy_io_address_decoder
